// ===== pkg/sram_link_pkg.sv
// Constants shared by both ends of the split-port burst SRAM link.
// Assumes one 40 MHz system clock on each side; the link clocks are plain pins.
//
// Summary of operation
// - Accesses begin only at positive input clock rise.
// - Read starts when read select samples low.
// - Deselected read finishes, then outputs float after clock.
// - Read data floats while read port deselected.
// - Write starts when write select samples low.
// - Deselected write port ignores data, memory untouched.
// - Write word captured on both input clock rises.
// - Read address at positive, write at negative.
// - Address ignored for a deselected port.
// - Lane selects sampled with their data word.
// - Lane zero gates low nine bits, one high.
// - 512K by 18 as two 256K arrays.
// - Every access moves two words per address.
// - Read words out on both output clock rises.
// - Inputs registered by input clocks, outputs by output.
// - Read and write ports run independently.
// - Array write completes itself after capture.
// - Low word after next input rise, then high.
// - Write word one at positive, two at negative.
// - Read of location being written returns newest data.
// - Output clocks held high selects single clock mode.
package sram_link_pkg;
    localparam int CLK_PERIOD_NS = 25;
    localparam int LINK_PERIOD_NS = 200;
    localparam int K_HALF_CYCLES = LINK_PERIOD_NS / (2 * CLK_PERIOD_NS);
    localparam int ADDR_BITS = 18;
    localparam int WORD_BITS = 18;
    localparam int LANE_BITS = 9;
    localparam int LANES = 2;
    localparam int ARRAY_DEPTH = 1 << ADDR_BITS;
    localparam int BUF_DEPTH = 2;
    // Edge pulses delayed so a fetched pair is in the buffer before a drain
    localparam int OUT_EDGE_DELAY = 2;
    // Controller sample phases, valid for K_HALF_CYCLES of 4 or 5
    localparam int LO_PICK_PHASE = 1;
    localparam int HI_PICK_PHASE = K_HALF_CYCLES + 1;
    localparam logic SEL_IDLE_N = 1'b1;
    localparam logic [LANES-1:0] LANES_OFF_N = 2'h3;
    localparam logic [WORD_BITS-1:0] WORD_RESET = 18'h0_0000;
    localparam logic [ADDR_BITS-1:0] ADDR_RESET = 18'h0_0000;
endpackage : sram_link_pkg

// ===== pkg/sram_link_if.sv
// Pins between the memory controller and the burst SRAM device.
// Read data is three-state: the wire level is resolved outside from rd_data_oe.
`timescale 1ns/10ps
interface sram_link_if;
    import sram_link_pkg::*;
    logic k;
    logic k_n;
    logic c;
    logic c_n;
    logic rd_port_sel_n;
    logic wr_port_sel_n;
    logic byte_lane_sel0_n;
    logic byte_lane_sel1_n;
    logic [ADDR_BITS-1:0] addr;
    logic [WORD_BITS-1:0] wr_data;
    logic [WORD_BITS-1:0] rd_data;
    logic rd_data_oe;

    modport device (
        input k, k_n, c, c_n, rd_port_sel_n, wr_port_sel_n,
        input byte_lane_sel0_n, byte_lane_sel1_n, addr, wr_data,
        output rd_data, rd_data_oe
    );
    modport controller (
        output k, k_n, c, c_n, rd_port_sel_n, wr_port_sel_n,
        output byte_lane_sel0_n, byte_lane_sel1_n, addr, wr_data,
        input rd_data, rd_data_oe
    );
endinterface : sram_link_if

// ===== logic/burst_sram_device.sv
// Burst-of-two SRAM with separate read and write ports on one address bus.
// All link pins are sampled by clk through two flip-flops; link clock edges are
// found from the sampled levels, so the link period must span several clk cycles.
`timescale 1ns/10ps
module burst_sram_device
    import sram_link_pkg::*;
#(
    parameter int DEPTH = ARRAY_DEPTH,
    parameter int FIFO_DEPTH = BUF_DEPTH
)
(
    // System clock and reset
    input wire logic clk,
    input wire logic srst,
    // Link to the controller
    sram_link_if.device link,
    // Status
    output logic singleClkMode
);
    localparam int IN_W = 8 + ADDR_BITS + WORD_BITS;
    localparam int PTR_W = (FIFO_DEPTH > 1) ? $clog2(FIFO_DEPTH) : 1;
    localparam int CNT_W = $clog2(FIFO_DEPTH + 1);
    localparam int PAIR_W = 2 * WORD_BITS;

    ////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers and link clock edges
    logic [IN_W-1:0] pinIn;
    logic [IN_W-1:0] syncA_reg;
    logic [IN_W-1:0] syncB_reg;
    logic [3:0] clkPrev_reg;
    logic kS, knS, cS, cnS, rdSelS, wrSelS, lane1S, lane0S;
    logic [ADDR_BITS-1:0] addrS;
    logic [WORD_BITS-1:0] dataS;
    wire kRise;
    wire knRise;
    wire outRise;
    wire outNRise;
    logic singleMode_reg;
    logic [OUT_EDGE_DELAY-1:0] outRiseDly_reg;
    logic [OUT_EDGE_DELAY-1:0] outNRiseDly_reg;

    assign pinIn = {link.k, link.k_n, link.c, link.c_n, link.rd_port_sel_n, link.wr_port_sel_n,
                    link.byte_lane_sel1_n, link.byte_lane_sel0_n, link.addr, link.wr_data};
    assign {kS, knS, cS, cnS, rdSelS, wrSelS, lane1S, lane0S, addrS, dataS} = syncB_reg;

    always_ff @(posedge clk) begin
        syncA_reg <= pinIn;
        syncB_reg <= syncA_reg;
    end

    // Seeded from the live level so reset never fakes an edge
    always_ff @(posedge clk) begin
        clkPrev_reg <= {kS, knS, cS, cnS};
    end

    assign kRise = kS & ~clkPrev_reg[3];
    assign knRise = knS & ~clkPrev_reg[2];
    assign outRise = singleMode_reg ? kRise : (cS & ~clkPrev_reg[1]);
    assign outNRise = singleMode_reg ? knRise : (cnS & ~clkPrev_reg[0]);

    // Strap caught while reset is held; fixed afterwards
    always_ff @(posedge clk) begin
        if (srst) begin
            singleMode_reg <= cS & cnS;
        end
    end
    assign singleClkMode = singleMode_reg;

    always_ff @(posedge clk) begin
        if (srst) begin
            outRiseDly_reg <= '0;
            outNRiseDly_reg <= '0;
        end else begin
            outRiseDly_reg <= {outRiseDly_reg[OUT_EDGE_DELAY-2:0], outRise};
            outNRiseDly_reg <= {outNRiseDly_reg[OUT_EDGE_DELAY-2:0], outNRise};
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Arrays: low word and high word of each address, 256K each
    logic [WORD_BITS-1:0] lowArr [0:DEPTH-1];
    logic [WORD_BITS-1:0] highArr [0:DEPTH-1];

    ////////////////////////////////////////////////////////////////////////////
    // Write port
    logic wrPend_reg;
    logic [WORD_BITS-1:0] wrWord0_reg;
    logic [LANES-1:0] wrMask0_reg;
    wire wrCommit;
    wire [LANES-1:0] laneMaskNow;

    assign laneMaskNow = ~{lane1S, lane0S};
    assign wrCommit = knRise & wrPend_reg;

    always_ff @(posedge clk) begin
        if (srst) begin
            wrPend_reg <= 1'b0;
            wrWord0_reg <= WORD_RESET;
            wrMask0_reg <= '0;
        end else if (kRise) begin
            wrPend_reg <= ~wrSelS;
            if (!wrSelS) begin
                wrWord0_reg <= dataS;
                wrMask0_reg <= laneMaskNow;
            end
        end else if (knRise) begin
            wrPend_reg <= 1'b0;
        end
    end

    // Whole burst lands in one clk at the negative input rise; no further strobe
    always_ff @(posedge clk) begin
        if (wrCommit) begin
            for (int l = 0; l < LANES; l++) begin
                if (wrMask0_reg[l]) begin
                    lowArr[addrS][l*LANE_BITS +: LANE_BITS] <= wrWord0_reg[l*LANE_BITS +: LANE_BITS];
                end
                if (laneMaskNow[l]) begin
                    highArr[addrS][l*LANE_BITS +: LANE_BITS] <= dataS[l*LANE_BITS +: LANE_BITS];
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read port: address at the start rise, fetch at the next rise
    logic rdPend_reg;
    logic [ADDR_BITS-1:0] rdAddr_reg;
    logic fetchWant_reg;
    logic [ADDR_BITS-1:0] fetchAddr_reg;
    wire fillReady;

    always_ff @(posedge clk) begin
        if (srst) begin
            rdPend_reg <= 1'b0;
            rdAddr_reg <= ADDR_RESET;
        end else if (kRise) begin
            rdPend_reg <= ~rdSelS;
            if (!rdSelS) begin
                rdAddr_reg <= addrS;
            end
        end
    end

    // A stalled fetch holds its address; a read started while it waits is dropped
    always_ff @(posedge clk) begin
        if (srst) begin
            fetchWant_reg <= 1'b0;
            fetchAddr_reg <= ADDR_RESET;
        end else if (kRise && rdPend_reg && !fetchWant_reg) begin
            fetchWant_reg <= 1'b1;
            fetchAddr_reg <= rdAddr_reg;
        end else if (fillReady) begin
            fetchWant_reg <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Two-entry pair buffer between array and output registers
    logic [PAIR_W-1:0] fifoMem [0:FIFO_DEPTH-1];
    logic [PTR_W-1:0] wrPtr_reg;
    logic [PTR_W-1:0] rdPtr_reg;
    logic [CNT_W-1:0] count_reg;
    wire fillValid;
    wire push;
    wire drainValid;
    wire drainReady;
    wire pop;
    wire [PAIR_W-1:0] headPair;

    assign fillValid = fetchWant_reg;
    assign fillReady = (count_reg != CNT_W'(FIFO_DEPTH));
    assign push = fillValid & fillReady;
    assign drainValid = (count_reg != '0);
    // Pop on a delayed output rise that finds a pair, matching the load of the output registers
    assign drainReady = outRiseDly_reg[OUT_EDGE_DELAY-1];
    assign pop = drainValid & drainReady;
    assign headPair = fifoMem[rdPtr_reg];

    // Array was written at the negative rise before this fetch, so a write begun
    // one rise earlier is already visible here
    always_ff @(posedge clk) begin
        if (push) begin
            fifoMem[wrPtr_reg] <= {highArr[fetchAddr_reg], lowArr[fetchAddr_reg]};
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            wrPtr_reg <= '0;
            rdPtr_reg <= '0;
            count_reg <= '0;
        end else begin
            if (push) begin
                wrPtr_reg <= (wrPtr_reg == PTR_W'(FIFO_DEPTH - 1)) ? '0 : wrPtr_reg + 1'b1;
            end
            if (pop) begin
                rdPtr_reg <= (rdPtr_reg == PTR_W'(FIFO_DEPTH - 1)) ? '0 : rdPtr_reg + 1'b1;
            end
            count_reg <= count_reg + CNT_W'(push) - CNT_W'(pop);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Output registers on the output clock pair
    logic [WORD_BITS-1:0] rdData_reg;
    logic rdDataOe_reg;
    logic [WORD_BITS-1:0] hiWord_reg;
    logic hiPend_reg;

    always_ff @(posedge clk) begin
        if (srst) begin
            rdData_reg <= WORD_RESET;
            rdDataOe_reg <= 1'b0;
            hiWord_reg <= WORD_RESET;
            hiPend_reg <= 1'b0;
        end else if (outRiseDly_reg[OUT_EDGE_DELAY-1]) begin
            if (drainValid) begin
                rdData_reg <= headPair[WORD_BITS-1:0];
                hiWord_reg <= headPair[PAIR_W-1:WORD_BITS];
                hiPend_reg <= 1'b1;
                rdDataOe_reg <= 1'b1;
            end else begin
                // Nothing left to send: float after this positive output rise
                rdDataOe_reg <= 1'b0;
                hiPend_reg <= 1'b0;
            end
        end else if (outNRiseDly_reg[OUT_EDGE_DELAY-1] && hiPend_reg) begin
            rdData_reg <= hiWord_reg;
            hiPend_reg <= 1'b0;
        end
    end

    // Both ports share only the array; neither stalls the other
    assign link.rd_data = rdData_reg;
    assign link.rd_data_oe = rdDataOe_reg;
endmodule : burst_sram_device

// ===== logic/burst_sram_controller.sv
// Memory controller end: makes the link clocks from clk by a divider and runs
// one read and one write burst per link period. Read data pins are synchronised.
`timescale 1ns/10ps
module burst_sram_controller
    import sram_link_pkg::*;
#(
    parameter int HALF_CYC = K_HALF_CYCLES,
    parameter bit SINGLE_CLK = 1'b0
)
(
    // System clock and reset
    input wire logic clk,
    input wire logic srst,
    // Link to the device
    sram_link_if.controller link,
    // Read requests
    input wire logic rdReq,
    input wire logic [ADDR_BITS-1:0] rdAddr,
    output logic rdReady,
    // Read answers
    output logic rdPairValid,
    output logic [WORD_BITS-1:0] rdWordLo,
    output logic [WORD_BITS-1:0] rdWordHi,
    // Write requests
    input wire logic wrReq,
    input wire logic [ADDR_BITS-1:0] wrAddr,
    input wire logic [WORD_BITS-1:0] wrWord0,
    input wire logic [WORD_BITS-1:0] wrWord1,
    input wire logic [LANES-1:0] wrLanes0N,
    input wire logic [LANES-1:0] wrLanes1N,
    output logic wrReady
);
    localparam int PH_W = $clog2(2 * HALF_CYC);
    localparam logic [PH_W-1:0] PH_LAST = PH_W'(2 * HALF_CYC - 1);
    localparam logic [PH_W-1:0] PH_HALF_END = PH_W'(HALF_CYC - 1);

    ////////////////////////////////////////////////////////////////////////////
    // Link clock divider
    logic [PH_W-1:0] phase_reg;
    logic k_reg;
    wire launchTick;
    wire secondTick;

    always_ff @(posedge clk) begin
        if (srst) begin
            phase_reg <= '0;
            k_reg <= 1'b1;
        end else begin
            phase_reg <= (phase_reg == PH_LAST) ? '0 : phase_reg + 1'b1;
            if (phase_reg == PH_LAST) begin
                k_reg <= 1'b1;
            end else if (phase_reg == PH_HALF_END) begin
                k_reg <= 1'b0;
            end
        end
    end

    // Pins move one clk before the link clock edge that samples them
    assign launchTick = (phase_reg == PH_LAST - 1'b1);
    assign secondTick = (phase_reg == PH_HALF_END - 1'b1);
    assign link.k = k_reg;
    assign link.k_n = ~k_reg;
    assign link.c = SINGLE_CLK ? 1'b1 : k_reg;
    assign link.c_n = SINGLE_CLK ? 1'b1 : ~k_reg;

    ////////////////////////////////////////////////////////////////////////////
    // Request launch
    logic rdSelN_reg;
    logic wrSelN_reg;
    logic [ADDR_BITS-1:0] addr_reg;
    logic [WORD_BITS-1:0] data_reg;
    logic [LANES-1:0] lanesN_reg;
    logic [ADDR_BITS-1:0] wrAddrHold_reg;
    logic [WORD_BITS-1:0] word1Hold_reg;
    logic [LANES-1:0] lanes1Hold_reg;

    assign rdReady = launchTick;
    assign wrReady = launchTick;

    always_ff @(posedge clk) begin
        if (srst) begin
            rdSelN_reg <= SEL_IDLE_N;
            wrSelN_reg <= SEL_IDLE_N;
            addr_reg <= ADDR_RESET;
            data_reg <= WORD_RESET;
            lanesN_reg <= LANES_OFF_N;
            wrAddrHold_reg <= ADDR_RESET;
            word1Hold_reg <= WORD_RESET;
            lanes1Hold_reg <= LANES_OFF_N;
        end else if (launchTick) begin
            rdSelN_reg <= ~rdReq;
            wrSelN_reg <= ~wrReq;
            addr_reg <= rdAddr;
            data_reg <= wrWord0;
            lanesN_reg <= wrLanes0N;
            wrAddrHold_reg <= wrAddr;
            word1Hold_reg <= wrWord1;
            lanes1Hold_reg <= wrLanes1N;
        end else if (secondTick) begin
            addr_reg <= wrAddrHold_reg;
            data_reg <= word1Hold_reg;
            lanesN_reg <= lanes1Hold_reg;
        end
    end

    assign link.rd_port_sel_n = rdSelN_reg;
    assign link.wr_port_sel_n = wrSelN_reg;
    assign link.addr = addr_reg;
    assign link.wr_data = data_reg;
    assign link.byte_lane_sel0_n = lanesN_reg[0];
    assign link.byte_lane_sel1_n = lanesN_reg[1];

    ////////////////////////////////////////////////////////////////////////////
    // Read return: pair arrives two link periods after the start rise
    logic [WORD_BITS-1:0] rdSyncA_reg;
    logic [WORD_BITS-1:0] rdSyncB_reg;
    logic [2:0] rdTrack_reg;
    logic [WORD_BITS-1:0] rdWordLo_reg;
    logic [WORD_BITS-1:0] rdWordHi_reg;
    logic rdPairValid_reg;
    wire loPick;
    wire hiPick;

    always_ff @(posedge clk) begin
        rdSyncA_reg <= link.rd_data;
        rdSyncB_reg <= rdSyncA_reg;
    end

    assign loPick = (phase_reg == PH_W'(LO_PICK_PHASE)) & rdTrack_reg[2];
    assign hiPick = (phase_reg == PH_W'(HI_PICK_PHASE)) & rdTrack_reg[2];

    always_ff @(posedge clk) begin
        if (srst) begin
            rdTrack_reg <= '0;
            rdWordLo_reg <= WORD_RESET;
            rdWordHi_reg <= WORD_RESET;
            rdPairValid_reg <= 1'b0;
        end else begin
            if (phase_reg == PH_LAST) begin
                rdTrack_reg <= {rdTrack_reg[1:0], ~rdSelN_reg};
            end
            if (loPick) begin
                rdWordLo_reg <= rdSyncB_reg;
            end
            if (hiPick) begin
                rdWordHi_reg <= rdSyncB_reg;
            end
            rdPairValid_reg <= hiPick;
        end
    end

    assign rdWordLo = rdWordLo_reg;
    assign rdWordHi = rdWordHi_reg;
    assign rdPairValid = rdPairValid_reg;
endmodule : burst_sram_controller

// ===== sim/split_port_ddr_burst_sram_assertions.sv
// Checker on the link pins between the burst SRAM controller and device.
// Assumes dual clock mode and a link period of eight clk cycles.
`timescale 1ns/10ps
module split_port_ddr_burst_sram_checker
    import sram_link_pkg::*;
(
    // System clock and reset
    input wire logic clk,
    input wire logic srst,
    // Link clocks
    input wire logic k,
    input wire logic k_n,
    input wire logic c,
    input wire logic c_n,
    // Selects and lanes
    input wire logic rd_port_sel_n,
    input wire logic wr_port_sel_n,
    input wire logic byte_lane_sel0_n,
    input wire logic byte_lane_sel1_n,
    // Address and data
    input wire logic [ADDR_BITS-1:0] addr,
    input wire logic [WORD_BITS-1:0] wr_data,
    input wire logic [WORD_BITS-1:0] rd_data,
    input wire logic rd_data_oe
);
    ////////////////////////////////////////////////
    // Longest legal drive after the last read select: one pair plus drain
    localparam int OE_HOLD_MAX = 18;
    logic [5:0] sinceRdSel_reg;
    logic [5:0] sinceRdSel_next;
    logic [5:0] sinceRdSel_inc;
    assign sinceRdSel_inc = (sinceRdSel_reg == 6'h3F) ? sinceRdSel_reg : sinceRdSel_reg + 6'h01;
    assign sinceRdSel_next = rd_port_sel_n ? sinceRdSel_inc : 6'h00;
    always_ff @(posedge clk) begin
        if (srst) begin
            sinceRdSel_reg <= 6'h3F;
        end else begin
            sinceRdSel_reg <= sinceRdSel_next;
        end
    end
    ////////////////////////////////////////////////
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (srst);
    sequence s_highHalf;
        (k && c && !k_n && !c_n)[*4];
    endsequence
    sequence s_lowHalf;
        (!k && !c && k_n && c_n)[*4];
    endsequence
    sequence s_readSelect;
        $fell(rd_port_sel_n);
    endsequence
    property p_clockShape;
        $rose(k) |-> s_highHalf ##1 s_lowHalf ##1 k;
    endproperty
    property p_resetFloat;
        $fell(srst) |-> !rd_data_oe;
    endproperty
    property p_selOnLowK;
        ($changed(rd_port_sel_n) || $changed(wr_port_sel_n)) |-> !k && k_n;
    endproperty
    property p_busLeadsClock;
        ($changed(addr) || $changed(wr_data) || $changed({byte_lane_sel1_n, byte_lane_sel0_n})) |=> $changed(k);
    endproperty
    property p_oeNeedsSelect;
        rd_data_oe |-> sinceRdSel_reg <= OE_HOLD_MAX;
    endproperty
    property p_readAnswers;
        s_readSelect |-> ##[10:18] rd_data_oe;
    endproperty
    property p_firstWordAfterC;
        $rose(rd_data_oe) |-> c_n && !c;
    endproperty
    property p_floatAfterC;
        $fell(rd_data_oe) |-> c_n && !c;
    endproperty
    a_clockShape: assert property (p_clockShape) else $error("link clock shape wrong");
    a_resetFloat: assert property (p_resetFloat) else $error("read data driven at reset");
    a_selOnLowK: assert property (p_selOnLowK) else $error("select moved near k rise");
    a_busLeadsClock: assert property (p_busLeadsClock) else $error("bus not set up before edge");
    a_oeNeedsSelect: assert property (p_oeNeedsSelect) else $error("read data driven while idle");
    a_readAnswers: assert property (p_readAnswers) else $error("read select got no data");
    a_firstWordAfterC: assert property (p_firstWordAfterC) else $error("first word off c timing");
    a_floatAfterC: assert property (p_floatAfterC) else $error("float not after c rise");
endmodule : split_port_ddr_burst_sram_checker

// ===== sim/test_split_port_ddr_burst_sram.sv
// Bench for the split-port burst SRAM link: controller and device face each other.
// Assumes HALF_CYC of 4; a second pair in single clock mode sees the same requests.
`timescale 1ns/10ps
`define CHECK(act, exp) begin compares++; if ((act) !== (exp)) begin failures++; \
    $display("[FAIL] %0t got %h expected %h", $time, (act), (exp)); end end
module test_split_port_ddr_burst_sram;
    import sram_link_pkg::*;
    typedef struct {
        logic [WORD_BITS-1:0] lo;
        logic [WORD_BITS-1:0] hi;
        time t;
    } note_t;
    localparam int LAT = 4 * K_HALF_CYCLES + HI_PICK_PHASE + 2;
    int failures = 0;
    int compares = 0;
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic rdReq = 1'b0;
    logic wrReq = 1'b0;
    logic [ADDR_BITS-1:0] rdAddr = ADDR_RESET;
    logic [ADDR_BITS-1:0] wrAddr = ADDR_RESET;
    logic [WORD_BITS-1:0] wrWord0 = WORD_RESET;
    logic [WORD_BITS-1:0] wrWord1 = WORD_RESET;
    logic [LANES-1:0] wrLanes0N = LANES_OFF_N;
    logic [LANES-1:0] wrLanes1N = LANES_OFF_N;
    logic rdReady, wrReady, rdPairValid, rdPairValid2, singleA, singleB;
    logic [WORD_BITS-1:0] rdWordLo, rdWordHi, rdWordLo2, rdWordHi2;
    logic [2*WORD_BITS-1:0] mem [logic [ADDR_BITS-1:0]];
    note_t notes[$];
    ////////////////////////////////////////////////
    sram_link_if linkA();
    sram_link_if linkB();
    burst_sram_controller i_burst_sram_controller (.clk(clk), .srst(srst), .link(linkA),
        .rdReq(rdReq), .rdAddr(rdAddr), .rdReady(rdReady), .rdPairValid(rdPairValid),
        .rdWordLo(rdWordLo), .rdWordHi(rdWordHi), .wrReq(wrReq), .wrAddr(wrAddr), .wrWord0(wrWord0),
        .wrWord1(wrWord1), .wrLanes0N(wrLanes0N), .wrLanes1N(wrLanes1N), .wrReady(wrReady));
    burst_sram_device i_burst_sram_device (.clk(clk), .srst(srst), .link(linkA), .singleClkMode(singleA));
    burst_sram_controller #(.SINGLE_CLK(1'b1)) i_burst_sram_controller_sc (.clk(clk), .srst(srst),
        .link(linkB), .rdReq(rdReq), .rdAddr(rdAddr), .rdReady(), .rdPairValid(rdPairValid2),
        .rdWordLo(rdWordLo2), .rdWordHi(rdWordHi2), .wrReq(wrReq), .wrAddr(wrAddr), .wrWord0(wrWord0),
        .wrWord1(wrWord1), .wrLanes0N(wrLanes0N), .wrLanes1N(wrLanes1N), .wrReady());
    burst_sram_device i_burst_sram_device_sc (.clk(clk), .srst(srst), .link(linkB), .singleClkMode(singleB));
    split_port_ddr_burst_sram_checker i_checker (.clk(clk), .srst(srst), .k(linkA.k), .k_n(linkA.k_n),
        .c(linkA.c), .c_n(linkA.c_n), .rd_port_sel_n(linkA.rd_port_sel_n), .wr_port_sel_n(linkA.wr_port_sel_n),
        .byte_lane_sel0_n(linkA.byte_lane_sel0_n), .byte_lane_sel1_n(linkA.byte_lane_sel1_n),
        .addr(linkA.addr), .wr_data(linkA.wr_data), .rd_data(linkA.rd_data), .rd_data_oe(linkA.rd_data_oe));
    ////////////////////////////////////////////////
    initial begin
        forever #(CLK_PERIOD_NS / 2.0) clk = ~clk;
    end
    function automatic logic [WORD_BITS-1:0] rw();
        rw = WORD_BITS'($urandom);
    endfunction : rw
    function automatic logic [WORD_BITS-1:0] merge(input logic [WORD_BITS-1:0] old,
                                                   input logic [WORD_BITS-1:0] nw, input logic [LANES-1:0] offN);
        merge = {offN[1] ? old[WORD_BITS-1:LANE_BITS] : nw[WORD_BITS-1:LANE_BITS],
                 offN[0] ? old[LANE_BITS-1:0] : nw[LANE_BITS-1:0]};
    endfunction : merge
    task automatic results();
        $display("comparisons %0d mismatches %0d", compares, failures);
        if (failures == 0 && compares > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : results
    // One link period: read and/or write taken at the ready edge; expectations noted first
    task automatic op(input logic r, input logic [ADDR_BITS-1:0] ra, input logic w,
                      input logic [ADDR_BITS-1:0] wa, input logic [WORD_BITS-1:0] d0,
                      input logic [WORD_BITS-1:0] d1, input logic [LANES-1:0] l0, input logic [LANES-1:0] l1);
        int n;
        logic [2*WORD_BITS-1:0] old;
        n = 0;
        // One edge between calls so no input is assigned twice in a time step
        @(posedge clk);
        #1;
        rdReq = r;
        rdAddr = ra;
        wrReq = w;
        wrAddr = wa;
        wrWord0 = d0;
        wrWord1 = d1;
        wrLanes0N = l0;
        wrLanes1N = l1;
        while (rdReady !== 1'b1 && n < 4 * K_HALF_CYCLES) begin
            @(posedge clk);
            #1;
            n++;
        end
        `CHECK(rdReady, 1'b1)
        `CHECK(wrReady, 1'b1)
        if (w) begin
            old = mem.exists(wa) ? mem[wa] : '0;
            mem[wa] = {merge(old[2*WORD_BITS-1:WORD_BITS], d1, l1), merge(old[WORD_BITS-1:0], d0, l0)};
        end
        // Same-period read of the written place sees the new pair: fetch follows the commit
        if (r) notes.push_back('{mem[ra][WORD_BITS-1:0], mem[ra][2*WORD_BITS-1:WORD_BITS], $time + CLK_PERIOD_NS - 1});
        @(posedge clk);
        #1;
        // Garbage on a deselected port must not reach the array
        rdReq = 1'b0;
        wrReq = 1'b0;
        wrAddr = ADDR_BITS'($urandom);
        wrWord0 = rw();
        wrWord1 = rw();
        wrLanes0N = LANES'($urandom);
        wrLanes1N = LANES'($urandom);
    endtask : op
    ////////////////////////////////////////////////
    always @(posedge clk) begin
        if (rdPairValid === 1'b1) begin
            `CHECK(notes.size() != 0, 1'b1)
            if (notes.size() != 0) begin
                `CHECK(rdWordLo, notes[0].lo)
                `CHECK(rdWordHi, notes[0].hi)
                `CHECK(int'(($time - notes[0].t) / CLK_PERIOD_NS) inside {LAT, LAT + 1}, 1'b1)
                `CHECK(rdPairValid2, 1'b1)
                `CHECK({rdWordHi2, rdWordLo2}, {notes[0].hi, notes[0].lo})
                void'(notes.pop_front());
            end
        end
    end
    initial begin
        #(CLK_PERIOD_NS * 5000);
        failures++;
        $display("[FAIL] %0t watchdog expired", $time);
        results();
    end
    initial begin
        int n;
        logic [ADDR_BITS-1:0] a [6];
        void'($urandom(95249));
        repeat (4) @(posedge clk);
        #1;
        srst = 1'b0;
        `CHECK(singleA, 1'b0)
        `CHECK(singleB, 1'b1)
        `CHECK(linkA.rd_data_oe, 1'b0)
        foreach (a[i]) a[i] = (i == 0) ? ADDR_RESET : (i == 1) ? ADDR_BITS'(ARRAY_DEPTH - 1) : ADDR_BITS'($urandom);
        foreach (a[i]) op(1'b0, ADDR_RESET, 1'b1, a[i], rw(), rw(), 2'h0, 2'h0);
        foreach (a[i]) begin
            op(1'b1, a[i], 1'b1, a[i], rw(), rw(), 2'(i), 2'(~i));
            op(1'b1, a[i], 1'b0, a[i], rw(), rw(), 2'h0, 2'h0);
        end
        repeat (3) op(1'b0, ADDR_BITS'($urandom), 1'b0, a[0], rw(), rw(), 2'h0, 2'h0);
        foreach (a[i]) op(1'b1, a[i], 1'b1, a[5 - i], rw(), rw(), 2'(~i), 2'(i));
        n = 0;
        while (notes.size() != 0 && n < 8 * LAT) begin
            @(posedge clk);
            n++;
        end
        `CHECK(notes.size(), 0)
        results();
    end
endmodule : test_split_port_ddr_burst_sram
